/* rtl/wake_evt_pkg.sv */
// constants of the wake-source and event-flag block
// assumes one system clock and a byte-wide register port
package wake_evt_pkg;

   // register port widths
   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;
   localparam int WAKE_SRC_N = 5;

   // register offsets
   localparam logic [15:0] OFS_EVENT_LOW = 16'h2700;
   localparam logic [15:0] OFS_EVENT_HIGH = 16'h2701;
   localparam logic [15:0] OFS_MASK_LOW = 16'h2710;
   localparam logic [15:0] OFS_MASK_HIGH = 16'h2711;
   localparam logic [15:0] OFS_WAKE_EN = 16'h28B3;
   localparam logic [15:0] OFS_PIN_INPUT = 16'h28B4;
   localparam logic [15:0] OFS_WAKE_CAUSE = 16'h28B5;
   localparam logic [15:0] OFS_MASK_WAKE = 16'h28B6;

   // first event register fields
   localparam int BIT_TRANSFER = 0;
   localparam int BIT_RTC_SEC = 1;
   localparam int BIT_RTC_MIN = 2;
   localparam int BIT_RTC_TEMP = 3;
   localparam int BIT_PULSE_X = 5;
   localparam int BIT_PULSE_Y = 6;
   localparam int BIT_EEPROM = 7;

   // second event register fields
   localparam int BIT_PULSE_V = 5;
   localparam int BIT_PULSE_W = 6;
   localparam int BIT_SPI = 7;

   // wake enable, wake cause and pin-input fields
   localparam int BIT_WAKE_PIN55 = 0;
   localparam int BIT_WAKE_PIN52 = 1;
   localparam int BIT_WAKE_PIN4 = 2;
   localparam int BIT_WAKE_BUTTON = 3;
   localparam int BIT_WAKE_SERIAL_RX = 4;

   // implemented bits, others read zero
   localparam logic [7:0] IMPL_EVENT_LOW = 8'hEF;
   localparam logic [7:0] IMPL_EVENT_HIGH = 8'hE0;
   localparam logic [7:0] IMPL_WAKE = 8'h1F;
   localparam logic [7:0] IMPL_PIN_INPUT = 8'h07;

   // reset values
   localparam logic [7:0] RST_EVENT = 8'h00;
   localparam logic [7:0] RST_MASK = 8'h00;
   localparam logic [7:0] RST_WAKE_EN = 8'h00;
   localparam logic [7:0] RST_PIN_INPUT = 8'h00;
   localparam logic [7:0] RST_WAKE_CAUSE = 8'h00;

   typedef enum logic {PWR_RUN, PWR_SLEEP} power_state_t;

endpackage : wake_evt_pkg

/* rtl/wake_sync_if.sv */
// bundle between the pin synchroniser and the wake logic
// assumes both ends share ref_clk
`timescale 1ns/1ps
interface wake_sync_if #(parameter int N = 5);
   logic [N-1:0] raw;
   logic [N-1:0] level;
   logic [N-1:0] rise;
   modport sync_side (input raw, output level, output rise);
   modport user_side (output raw, input level, input rise);
endinterface : wake_sync_if

/* rtl/pin_edge_sync.sv */
// three-stage pin synchroniser with agreement filter and rise detect
// assumes raw pins are asynchronous to ref_clk
`timescale 1ns/1ps
module pin_edge_sync #(
   parameter int N = 5
) (
   input wire logic ref_clk,
   input wire logic rst_b,
   wake_sync_if.sync_side pins
);
   logic [N-1:0] s1_q;
   logic [N-1:0] s2_q;
   logic [N-1:0] s3_q;
   logic [N-1:0] level_q;
   logic [N-1:0] level_d;
   logic [N-1:0] rise_q;

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
      end else begin
         s1_q <= pins.raw;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // level moves only when stages two and three agree
   always_comb begin
      level_d = (s2_q & s3_q) | (level_q & (s2_q ^ s3_q));
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         level_q <= '0;
         rise_q <= '0;
      end else begin
         level_q <= level_d;
         rise_q <= level_d & ~level_q;
      end
   end

   assign pins.level = level_q;
   assign pins.rise = rise_q;

endmodule : pin_edge_sync

/* rtl/wake_event_ctrl.sv */
// wake-source selection, event flags and interrupt output
// assumes event inputs are one-cycle pulses on ref_clk and
// wake pins are asynchronous
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps

module wake_event_ctrl
   import wake_evt_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic [wake_evt_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [wake_evt_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [wake_evt_pkg::DATA_W-1:0] reg_rdata,
   input wire logic push_button_in,
   input wire logic serial_rx_in,
   input wire logic shared_pin_4,
   input wire logic shared_pin_52,
   input wire logic shared_pin_55,
   input wire logic transfer_busy_event,
   input wire logic rtc_second_tick,
   input wire logic rtc_minute_tick,
   input wire logic rtc_temperature_event,
   input wire logic spi_event,
   input wire logic eeprom_event,
   input wire logic pulse_x_event,
   input wire logic pulse_y_event,
   input wire logic pulse_v_event,
   input wire logic pulse_w_event,
   input wire logic sleep_req,
   output logic low_power,
   output logic wake_req,
   output logic irq
);
   import wake_evt_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // register state

   logic [7:0] event_flags_low_q;
   logic [7:0] event_flags_low_d;
   logic [7:0] event_flags_high_q;
   logic [7:0] event_flags_high_d;
   logic [7:0] mask_low_q;
   logic [7:0] mask_high_q;
   logic [7:0] wake_source_enables_q;
   logic [7:0] pin_input_q;
   logic [7:0] wake_cause_q;
   logic [7:0] wake_cause_d;
   logic [7:0] mask_wake_q;
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;
   logic wake_req_q;
   logic irq_q;
   power_state_t pwr_q;
   power_state_t pwr_d;

   logic [7:0] set_low;
   logic [7:0] set_high;
   logic [WAKE_SRC_N-1:0] src_qual;
   logic [WAKE_SRC_N-1:0] src_hit;
   logic any_wake;

   ////////////////////////////////////////////////////////////////////
   // address decode helpers

   function automatic logic wr_hit(input logic [15:0] ofs);
      wr_hit = reg_wr && (reg_addr == ofs);
   endfunction : wr_hit

   function automatic logic [7:0] field_wr(input logic [15:0] ofs,
                                           input logic [7:0] impl);
      field_wr = wr_hit(ofs) ? (reg_wdata & impl) : 8'h00;
   endfunction : field_wr

   // mask value after this edge, so irq follows a mask write at once
   function automatic logic [7:0] mask_nxt(input logic [15:0] ofs,
                                           input logic [7:0] cur,
                                           input logic [7:0] impl);
      mask_nxt = wr_hit(ofs) ? (reg_wdata & impl) : cur;
   endfunction : mask_nxt

   ////////////////////////////////////////////////////////////////////
   // wake pin synchroniser

   wake_sync_if #(.N(WAKE_SRC_N)) pins_if ();

   assign pins_if.raw[BIT_WAKE_BUTTON] = push_button_in;
   assign pins_if.raw[BIT_WAKE_SERIAL_RX] = serial_rx_in;
   assign pins_if.raw[BIT_WAKE_PIN4] = shared_pin_4;
   assign pins_if.raw[BIT_WAKE_PIN52] = shared_pin_52;
   assign pins_if.raw[BIT_WAKE_PIN55] = shared_pin_55;

   pin_edge_sync #(.N(WAKE_SRC_N)) u_sync (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .pins(pins_if.sync_side)
   );

   ////////////////////////////////////////////////////////////////////
   // wake source qualification

   always_comb begin
      src_qual[BIT_WAKE_BUTTON] = 1'b1;
      src_qual[BIT_WAKE_SERIAL_RX] = 1'b1;
      src_qual[BIT_WAKE_PIN4] = pin_input_q[BIT_WAKE_PIN4];
      src_qual[BIT_WAKE_PIN52] = pin_input_q[BIT_WAKE_PIN52];
      src_qual[BIT_WAKE_PIN55] = pin_input_q[BIT_WAKE_PIN55];
   end

   assign src_hit = pins_if.rise
                  & wake_source_enables_q[WAKE_SRC_N-1:0]
                  & src_qual;

   assign any_wake = |src_hit;

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         wake_req_q <= 1'b0;
      end else begin
         wake_req_q <= any_wake;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // power state

   always_comb begin
      pwr_d = pwr_q;
      case (pwr_q)
         PWR_RUN: begin
            if (sleep_req && !any_wake) begin
               pwr_d = PWR_SLEEP;
            end
         end
         PWR_SLEEP: begin
            if (any_wake) begin
               pwr_d = PWR_RUN;
            end
         end
         default: begin
            pwr_d = PWR_RUN;
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         pwr_q <= PWR_RUN;
      end else begin
         pwr_q <= pwr_d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // event flags

   always_comb begin
      set_low = 8'h00;
      set_high = 8'h00;
      set_low[BIT_TRANSFER] = transfer_busy_event;
      set_low[BIT_RTC_SEC] = rtc_second_tick;
      set_low[BIT_RTC_MIN] = rtc_minute_tick;
      set_low[BIT_RTC_TEMP] = rtc_temperature_event;
      set_low[BIT_PULSE_X] = pulse_x_event;
      set_low[BIT_PULSE_Y] = pulse_y_event;
      set_low[BIT_EEPROM] = eeprom_event;
      set_high[BIT_PULSE_V] = pulse_v_event;
      set_high[BIT_PULSE_W] = pulse_w_event;
      set_high[BIT_SPI] = spi_event;
   end

   // written ones only keep; zeros clear
   always_comb begin
      event_flags_low_d = event_flags_low_q;
      if (wr_hit(OFS_EVENT_LOW)) begin
         event_flags_low_d = event_flags_low_q & reg_wdata;
      end
      // set wins over a same-cycle clear
      event_flags_low_d = (event_flags_low_d | set_low) & IMPL_EVENT_LOW;
   end

   always_comb begin
      event_flags_high_d = event_flags_high_q;
      if (wr_hit(OFS_EVENT_HIGH)) begin
         event_flags_high_d = event_flags_high_q & reg_wdata;
      end
      event_flags_high_d = (event_flags_high_d | set_high)
                         & IMPL_EVENT_HIGH;
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         event_flags_low_q <= RST_EVENT;
         event_flags_high_q <= RST_EVENT;
      end else begin
         event_flags_low_q <= event_flags_low_d;
         event_flags_high_q <= event_flags_high_d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // wake cause, cleared by writing one

   always_comb begin
      wake_cause_d = wake_cause_q & ~field_wr(OFS_WAKE_CAUSE, IMPL_WAKE);
      wake_cause_d[WAKE_SRC_N-1:0] = wake_cause_d[WAKE_SRC_N-1:0]
                                   | src_hit;
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         wake_cause_q <= RST_WAKE_CAUSE;
      end else begin
         wake_cause_q <= wake_cause_d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // configuration registers

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         wake_source_enables_q <= RST_WAKE_EN;
      end else if (wr_hit(OFS_WAKE_EN)) begin
         wake_source_enables_q <= reg_wdata & IMPL_WAKE;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         pin_input_q <= RST_PIN_INPUT;
      end else if (wr_hit(OFS_PIN_INPUT)) begin
         pin_input_q <= reg_wdata & IMPL_PIN_INPUT;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         mask_low_q <= RST_MASK;
         mask_high_q <= RST_MASK;
         mask_wake_q <= RST_MASK;
      end else begin
         if (wr_hit(OFS_MASK_LOW)) begin
            mask_low_q <= reg_wdata & IMPL_EVENT_LOW;
         end
         if (wr_hit(OFS_MASK_HIGH)) begin
            mask_high_q <= reg_wdata & IMPL_EVENT_HIGH;
         end
         if (wr_hit(OFS_MASK_WAKE)) begin
            mask_wake_q <= reg_wdata & IMPL_WAKE;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // interrupt output

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(event_flags_low_d
                    & mask_nxt(OFS_MASK_LOW, mask_low_q, IMPL_EVENT_LOW))
                | |(event_flags_high_d
                    & mask_nxt(OFS_MASK_HIGH, mask_high_q, IMPL_EVENT_HIGH))
                | |(wake_cause_d
                    & mask_nxt(OFS_MASK_WAKE, mask_wake_q, IMPL_WAKE));
      end
   end

   ////////////////////////////////////////////////////////////////////
   // read port, data valid only in the cycle after the strobe

   always_comb begin
      rdata_d = 8'h00;
      if (reg_rd) begin
         case (reg_addr)
            OFS_EVENT_LOW: rdata_d = event_flags_low_q;
            OFS_EVENT_HIGH: rdata_d = event_flags_high_q;
            OFS_MASK_LOW: rdata_d = mask_low_q;
            OFS_MASK_HIGH: rdata_d = mask_high_q;
            OFS_WAKE_EN: rdata_d = wake_source_enables_q;
            OFS_PIN_INPUT: rdata_d = pin_input_q;
            OFS_WAKE_CAUSE: rdata_d = wake_cause_q;
            OFS_MASK_WAKE: rdata_d = mask_wake_q;
            default: rdata_d = 8'h00;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign reg_rdata = rdata_q;
   assign wake_req = wake_req_q;
   assign irq = irq_q;
   assign low_power = (pwr_q == PWR_SLEEP);

endmodule : wake_event_ctrl

/* bench/wake_event_chk.sv */
// checker for the wake and event block, top ports only
// assumes one ref_clk domain and active-low rst_b
`timescale 1ns/1ps
module wake_event_chk (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_addr,
   input wire logic [7:0] reg_rdata,
   input wire logic push_button_in,
   input wire logic serial_rx_in,
   input wire logic shared_pin_4,
   input wire logic shared_pin_52,
   input wire logic shared_pin_55,
   input wire logic sleep_req,
   input wire logic low_power,
   input wire logic wake_req,
   input wire logic irq
);
   logic [4:0] pins;
   logic [4:0] pins_q;
   logic [3:0] pin_age_q;
   assign pins = {serial_rx_in, push_button_in, shared_pin_4,
      shared_pin_52, shared_pin_55};
   // cycles since the last rise on any wake pin
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         pins_q <= 5'h00;
         pin_age_q <= 4'hF;
      end else begin
         pins_q <= pins;
         if (|(pins & ~pins_q)) pin_age_q <= 4'h0;
         else if (pin_age_q != 4'hF) pin_age_q <= pin_age_q + 4'h1;
      end
   end
   ////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   property p_rdata_idle; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
   a_rdata_idle: assert property (p_rdata_idle)
      else $error("read data outside read slot");
   property p_unmapped; reg_rd && reg_addr == 16'h1234 |=> reg_rdata == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read not zero");
   property p_wake_cause; wake_req |-> pin_age_q <= 4'h6; endproperty
   a_wake_cause: assert property (p_wake_cause)
      else $error("wake without pin rise");
   property p_lp_exit; $fell(low_power) |-> wake_req; endproperty
   a_lp_exit: assert property (p_lp_exit)
      else $error("sleep left without wake");
   property p_lp_entry; $rose(low_power) |-> $past(sleep_req); endproperty
   a_lp_entry: assert property (p_lp_entry)
      else $error("sleep entered without request");
   property p_lp_hold; low_power && pin_age_q == 4'hF |=> low_power;
   endproperty
   a_lp_hold: assert property (p_lp_hold)
      else $error("sleep left with quiet pins");
   property p_irq_hold; irq && !reg_wr |=> irq; endproperty
   a_irq_hold: assert property (p_irq_hold)
      else $error("irq dropped without write");
   property p_irq_fall; $fell(irq) |-> $past(reg_wr); endproperty
   a_irq_fall: assert property (p_irq_fall)
      else $error("irq fell without write");
endmodule : wake_event_chk
bind wake_event_ctrl wake_event_chk chk (.ref_clk(ref_clk), .rst_b(rst_b),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
   .reg_rdata(reg_rdata), .push_button_in(push_button_in),
   .serial_rx_in(serial_rx_in), .shared_pin_4(shared_pin_4),
   .shared_pin_52(shared_pin_52), .shared_pin_55(shared_pin_55),
   .sleep_req(sleep_req), .low_power(low_power), .wake_req(wake_req),
   .irq(irq));

/* bench/wake_pin_model.sv */
// model of the external wake pins
// assumes one fire bit at a time; pins rest low between pulses
`timescale 1ns/1ps
module wake_pin_model (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic [4:0] fire,
   output logic [4:0] pins
);
   logic [2:0] hold_q;
   // button line is a plain input, driven here like the others
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         pins <= 5'h00;
         hold_q <= 3'h0;
      end else if (|fire) begin
         pins <= fire;
         hold_q <= 3'h5;
      end else if (hold_q == 3'h1) begin
         pins <= 5'h00;
         hold_q <= 3'h0;
      end else if (hold_q != 3'h0) begin
         hold_q <= hold_q - 3'h1;
      end
   end
endmodule : wake_pin_model

/* bench/wake_event_ctrl_tb.sv */
// self-checking bench for the wake and event block
// assumes the pin model in wake_pin_model.sv
`timescale 1ns/1ps
module wake_event_ctrl_tb;
   import wake_evt_pkg::*;
   logic ref_clk = 1'b0;
   logic rst_b = 1'b0;
   logic [15:0] reg_addr = 16'h0000;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic [9:0] ev = 10'h000;
   logic [4:0] fire = 5'h00;
   logic [4:0] pins;
   logic sleep_req = 1'b0;
   logic low_power, wake_req, irq;
   int num_errors = 0;
   int cmp_count = 0;
   int cycles = 0;
   always #20 ref_clk = ~ref_clk;
   wake_pin_model pm (.ref_clk(ref_clk), .rst_b(rst_b), .fire(fire),
      .pins(pins));
   wake_event_ctrl DUT (.ref_clk(ref_clk), .rst_b(rst_b),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .push_button_in(pins[3]), .serial_rx_in(pins[4]),
      .shared_pin_4(pins[2]), .shared_pin_52(pins[1]),
      .shared_pin_55(pins[0]), .transfer_busy_event(ev[0]),
      .rtc_second_tick(ev[1]), .rtc_minute_tick(ev[2]),
      .rtc_temperature_event(ev[3]), .spi_event(ev[4]),
      .eeprom_event(ev[5]), .pulse_x_event(ev[6]), .pulse_y_event(ev[7]),
      .pulse_v_event(ev[8]), .pulse_w_event(ev[9]), .sleep_req(sleep_req),
      .low_power(low_power), .wake_req(wake_req), .irq(irq));
   ////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [15:0] a, input logic [7:0] exp);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      @(negedge ref_clk);
      chk(reg_rdata, exp);
   endtask : rd
   task automatic pulse(input logic [9:0] v);
      @(posedge ref_clk);
      ev <= v;
      @(posedge ref_clk);
      ev <= 10'h000;
   endtask : pulse
   ////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      rd(OFS_WAKE_EN, 8'h00);
      rd(OFS_EVENT_LOW, 8'h00);
      rd(OFS_EVENT_HIGH, 8'h00);
      rd(16'h1234, 8'h00);
   endtask : t_reset
   task automatic t_events;
      pulse(10'h3FF);
      rd(OFS_EVENT_LOW, 8'hEF);
      rd(OFS_EVENT_HIGH, 8'hE0);
      wr(OFS_EVENT_LOW, 8'hFF);
      rd(OFS_EVENT_LOW, 8'hEF);
      wr(OFS_EVENT_LOW, 8'h02);
      rd(OFS_EVENT_LOW, 8'h02);
      wr(OFS_EVENT_LOW, 8'h00);
      wr(OFS_EVENT_HIGH, 8'h00);
      rd(OFS_EVENT_HIGH, 8'h00);
      wr(OFS_EVENT_LOW, 8'hFF);
      rd(OFS_EVENT_LOW, 8'h00);
   endtask : t_events
   // the processor-side enable lies beyond irq
   task automatic t_irq;
      wr(OFS_MASK_LOW, 8'h02);
      pulse(10'h004);
      @(negedge ref_clk);
      chk({7'h00, irq}, 8'h00);
      pulse(10'h002);
      @(negedge ref_clk);
      chk({7'h00, irq}, 8'h01);
      wr(OFS_MASK_LOW, 8'h00);
      @(negedge ref_clk);
      chk({7'h00, irq}, 8'h00);
      wr(OFS_MASK_LOW, 8'h02);
      @(negedge ref_clk);
      chk({7'h00, irq}, 8'h01);
      wr(OFS_EVENT_LOW, 8'h00);
      @(negedge ref_clk);
      chk({7'h00, irq}, 8'h00);
      wr(OFS_MASK_HIGH, 8'h80);
      pulse(10'h010);
      @(negedge ref_clk);
      chk({7'h00, irq}, 8'h01);
      wr(OFS_EVENT_HIGH, 8'h00);
      @(negedge ref_clk);
      chk({7'h00, irq}, 8'h00);
   endtask : t_irq
   task automatic try_wake(input int i, input logic [7:0] en,
      input logic [7:0] q, input logic exp);
      logic seen;
      seen = 1'b0;
      wr(OFS_PIN_INPUT, q);
      wr(OFS_WAKE_EN, en);
      @(posedge ref_clk);
      sleep_req <= 1'b1;
      @(posedge ref_clk);
      sleep_req <= 1'b0;
      fire <= 5'h01 << i;
      @(posedge ref_clk);
      fire <= 5'h00;
      repeat (10) begin
         @(negedge ref_clk);
         seen = seen | wake_req;
      end
      chk({7'h00, seen}, {7'h00, exp});
      chk({7'h00, low_power}, {7'h00, ~exp});
   endtask : try_wake
   task automatic t_wake;
      logic [7:0] b;
      for (int i = 0; i < 5; i++) begin
         b = 8'h01 << i;
         try_wake(i, 8'h00, 8'h07, 1'b0);
         try_wake(i, b, 8'h00, i > 2);
         try_wake(i, b, 8'h07, 1'b1);
      end
      rd(OFS_WAKE_CAUSE, 8'h1F);
      wr(OFS_MASK_WAKE, 8'h1F);
      @(negedge ref_clk);
      chk({7'h00, irq}, 8'h01);
      wr(OFS_WAKE_CAUSE, 8'h1F);
      @(negedge ref_clk);
      chk({7'h00, irq}, 8'h00);
      rd(OFS_WAKE_CAUSE, 8'h00);
   endtask : t_wake
   ////////////////////////////////////////////////////////////////////
   task automatic final_report;
      if (num_errors == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : final_report
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 5000) begin
         num_errors++;
         final_report();
      end
   end
   initial begin
      repeat (4) @(posedge ref_clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge ref_clk);
      t_reset();
      t_events();
      t_irq();
      t_wake();
      final_report();
   end
endmodule : wake_event_ctrl_tb
